// file: src/arl_timer_pkg.sv
// Constants and carrier types of the auto-reload timer output block
package arl_timer_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] MASK_LO_ADDR = 8'hE0;
  localparam logic [7:0] FLAGS_ADDR = 8'hE2;
  localparam logic [7:0] PINCFG_ADDR = 8'hE3;
  localparam logic [7:0] RELOAD_CAPTURE_HIGH_HI_ADDR = 8'hE9;
  localparam logic [7:0] RELOAD_CAPTURE_HIGH_LO_ADDR = 8'hEA;
  localparam logic [7:0] CAPT_HI_ADDR = 8'hEB;
  localparam logic [7:0] CAPT_LO_ADDR = 8'hEC;
  localparam logic [7:0] CMP_HI_ADDR = 8'hED;
  localparam logic [7:0] CMP_LO_ADDR = 8'hEE;
  localparam logic [7:0] MASK_HI_ADDR = 8'hEF;

  // ****************************************
  // Field positions, event_flags_control
  // ****************************************
  localparam int EB_POL_BIT = 7;
  localparam int EB_IEN_BIT = 6;
  localparam int EB_FLG_BIT = 5;
  localparam int MT_IEN_BIT = 4;
  localparam int MT_FLG_BIT = 3;
  localparam int ZR_IEN_BIT = 2;
  localparam int ZR_FLG_BIT = 1;
  localparam int WV_TGL_BIT = 0;

  // ****************************************
  // Field positions, output_pin_config
  // ****************************************
  localparam int WR_POL_BIT = 3;
  localparam int WR_EN_BIT = 2;
  localparam int WV_POL_BIT = 1;
  localparam int WV_EN_BIT = 0;
  localparam logic [7:0] PINCFG_MASK = 8'h0F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } arl_bus_req_t;

  // Signals from the counter and the rest of the timer, same clock
  typedef struct packed {
    logic [15:0] count;
    logic run_clear;
    logic reload_enable;
    logic wrap_event;
    logic wrap_flag;
    logic wrap_irq_enable;
    logic wrap_toggle_select;
    logic edge_a_flag;
    logic edge_a_irq_enable;
    logic edge_a_capture;
  } arl_core_t;

endpackage

// file: src/arl_timer_out.sv
// Status, compare and output-pin logic of a 16-bit auto-reload timer
`timescale 1ns/100ps

// Functional notes
// - edge_b polarity picks falling or rising edge
// - edge_b enable gates edge_b flag onto interrupt
// - first edge_b capture sets flag; clear only
// - match enable gates match flag onto interrupt
// - masked compare sets match flag; clear only
// - zero enable gates zero flag onto interrupt
// - masked zero sets flag unless held cleared
// - wave mode: set/reset or toggle on compare
// - match when mask&count equals mask&compare
// - zero when mask&count equals zero
// - wrap pin polarity sets active and idle level
// - wrap pin disabled holds polarity level
// - wave polarity inverts set/reset and idle
// - wave pin disabled holds polarity level
// - high byte write goes to latch only
// - high byte read returns loaded value
// - reload/capture writable only when reload enabled
// - capture register read-only, writes ignored
// - compare and mask registers read/write
// - interrupt is OR of five flag-enable pairs
// - wrap pin set mode or toggle mode
// - run_clear low stops events and synchronisers
module arl_timer_out (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire arl_timer_pkg::arl_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Counter and rest of the timer
  input wire arl_timer_pkg::arl_core_t core,
  // Pins
  input wire logic edge_b_input,
  output logic wave_out,
  output logic wrap_out_pin,
  // Interrupt and capture view
  output logic timer_irq,
  output logic edge_b_capture
);

  // ****************************************
  // Address decode
  // ****************************************
  logic wr_flags;
  logic wr_pincfg;
  logic wr_rl_hi;
  logic wr_rl_lo;
  logic wr_cmp_hi;
  logic wr_cmp_lo;
  logic wr_msk_hi;
  logic wr_msk_lo;

  assign wr_flags = bus_req.wr && bus_req.addr == arl_timer_pkg::FLAGS_ADDR;
  assign wr_pincfg = bus_req.wr && bus_req.addr == arl_timer_pkg::PINCFG_ADDR;
  assign wr_rl_hi = bus_req.wr && core.reload_enable
    && bus_req.addr == arl_timer_pkg::RELOAD_CAPTURE_HIGH_HI_ADDR;
  assign wr_rl_lo = bus_req.wr && core.reload_enable
    && bus_req.addr == arl_timer_pkg::RELOAD_CAPTURE_HIGH_LO_ADDR;
  assign wr_cmp_hi = bus_req.wr && bus_req.addr == arl_timer_pkg::CMP_HI_ADDR;
  assign wr_cmp_lo = bus_req.wr && bus_req.addr == arl_timer_pkg::CMP_LO_ADDR;
  assign wr_msk_hi = bus_req.wr && bus_req.addr == arl_timer_pkg::MASK_HI_ADDR;
  assign wr_msk_lo = bus_req.wr && bus_req.addr == arl_timer_pkg::MASK_LO_ADDR;

  // ****************************************
  // Control bits
  // ****************************************
  logic edge_b_polarity_q;
  logic edge_b_irq_enable_q;
  logic match_irq_enable_q;
  logic zero_irq_enable_q;
  logic wave_toggle_select_q;
  logic [3:0] pincfg_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_b_polarity_q <= 1'b0;
      edge_b_irq_enable_q <= 1'b0;
      match_irq_enable_q <= 1'b0;
      zero_irq_enable_q <= 1'b0;
      wave_toggle_select_q <= 1'b0;
    end else if (wr_flags) begin
      edge_b_polarity_q <= bus_req.wdata[arl_timer_pkg::EB_POL_BIT];
      edge_b_irq_enable_q <= bus_req.wdata[arl_timer_pkg::EB_IEN_BIT];
      match_irq_enable_q <= bus_req.wdata[arl_timer_pkg::MT_IEN_BIT];
      zero_irq_enable_q <= bus_req.wdata[arl_timer_pkg::ZR_IEN_BIT];
      wave_toggle_select_q <= bus_req.wdata[arl_timer_pkg::WV_TGL_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pincfg_q <= 4'h0;
    end else if (wr_pincfg) begin
      pincfg_q <= bus_req.wdata[3:0];
    end
  end

  logic wrap_out_polarity;
  logic wrap_out_enable;
  logic wave_polarity;
  logic wave_enable;

  assign wrap_out_polarity = pincfg_q[arl_timer_pkg::WR_POL_BIT];
  assign wrap_out_enable = pincfg_q[arl_timer_pkg::WR_EN_BIT];
  assign wave_polarity = pincfg_q[arl_timer_pkg::WV_POL_BIT];
  assign wave_enable = pincfg_q[arl_timer_pkg::WV_EN_BIT];

  // ****************************************
  // 16-bit registers with high-byte latch
  // ****************************************
  logic [7:0] rl_latch_q;
  logic [7:0] cmp_latch_q;
  logic [7:0] msk_latch_q;
  logic [15:0] reload_capture_q;
  logic [15:0] capture_q;
  logic [15:0] compare_q;
  logic [15:0] mask_q;

  // high byte held until low write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rl_latch_q <= arl_timer_pkg::BYTE_RST;
      cmp_latch_q <= arl_timer_pkg::BYTE_RST;
      msk_latch_q <= arl_timer_pkg::BYTE_RST;
    end else begin
      if (wr_rl_hi) begin
        rl_latch_q <= bus_req.wdata;
      end
      if (wr_cmp_hi) begin
        cmp_latch_q <= bus_req.wdata;
      end
      if (wr_msk_hi) begin
        msk_latch_q <= bus_req.wdata;
      end
    end
  end

  // Hardware capture from the other edge wins over a software load
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_capture_q <= arl_timer_pkg::WORD_RST;
    end else if (core.edge_a_capture) begin
      reload_capture_q <= core.count;
    end else if (wr_rl_lo) begin
      // whole word loads with low byte
      reload_capture_q <= {rl_latch_q, bus_req.wdata};
    end
  end

  // compare and mask load on low byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_q <= arl_timer_pkg::WORD_RST;
      mask_q <= arl_timer_pkg::WORD_RST;
    end else begin
      if (wr_cmp_lo) begin
        compare_q <= {cmp_latch_q, bus_req.wdata};
      end
      if (wr_msk_lo) begin
        mask_q <= {msk_latch_q, bus_req.wdata};
      end
    end
  end

  // ****************************************
  // Edge input synchroniser and detector
  // ****************************************
  logic eb_meta_q;
  logic eb_sync_q;
  logic eb_prev_q;
  logic [2:0] eb_arm_q;
  logic eb_edge;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eb_meta_q <= 1'b0;
      eb_sync_q <= 1'b0;
      eb_prev_q <= 1'b0;
      eb_arm_q <= 3'h0;
    end else if (!core.run_clear) begin
      eb_meta_q <= 1'b0;
      eb_sync_q <= 1'b0;
      eb_prev_q <= 1'b0;
      eb_arm_q <= 3'h0;
    end else begin
      eb_meta_q <= edge_b_input;
      eb_sync_q <= eb_meta_q;
      eb_prev_q <= eb_sync_q;
      eb_arm_q <= {eb_arm_q[1:0], 1'b1};
    end
  end

  // polarity selects active edge
  // Armed once prev holds a real pin sample, so a high pin gives no false edge at start
  assign eb_edge = core.run_clear && eb_arm_q[2] && (edge_b_polarity_q
    ? (eb_sync_q && !eb_prev_q) : (!eb_sync_q && eb_prev_q));

  logic edge_b_flag_q;

  assign edge_b_capture = eb_edge && !edge_b_flag_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_q <= arl_timer_pkg::WORD_RST;
    end else if (edge_b_capture) begin
      capture_q <= core.count;
    end
  end

  // ****************************************
  // Masked compare and masked zero
  // ****************************************
  logic match_lvl;
  logic zero_lvl;
  logic match_prev_q;
  logic zero_prev_q;
  logic match_evt;
  logic zero_evt;

  assign match_lvl = core.run_clear
    && ((mask_q & core.count) == (mask_q & compare_q));
  assign zero_lvl = core.run_clear
    && ((mask_q & core.count) == arl_timer_pkg::WORD_RST);

  // Events on entry so toggle mode steps once per match
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_prev_q <= 1'b0;
      zero_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match_lvl;
      zero_prev_q <= zero_lvl;
    end
  end

  assign match_evt = match_lvl && !match_prev_q;
  assign zero_evt = zero_lvl && !zero_prev_q;

  // ****************************************
  // Sticky flags, set wins over clear
  // ****************************************
  logic match_flag_q;
  logic zero_flag_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_b_flag_q <= 1'b0;
    end else if (edge_b_capture) begin
      edge_b_flag_q <= 1'b1;
    end else if (wr_flags && !bus_req.wdata[arl_timer_pkg::EB_FLG_BIT]) begin
      edge_b_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_flag_q <= 1'b0;
    end else if (match_lvl) begin
      match_flag_q <= 1'b1;
    end else if (wr_flags && !bus_req.wdata[arl_timer_pkg::MT_FLG_BIT]) begin
      match_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_flag_q <= 1'b0;
    end else if (zero_lvl) begin
      zero_flag_q <= 1'b1;
    end else if (wr_flags && !bus_req.wdata[arl_timer_pkg::ZR_FLG_BIT]) begin
      zero_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // five flag-enable pairs; gates
  assign timer_irq = (core.edge_a_flag && core.edge_a_irq_enable)
    || (edge_b_flag_q && edge_b_irq_enable_q)
    || (core.wrap_flag && core.wrap_irq_enable)
    || (match_flag_q && match_irq_enable_q)
    || (zero_flag_q && zero_irq_enable_q);

  // ****************************************
  // Waveform output
  // ****************************************
  logic wave_state_q;
  logic wave_out_q;

  // set/reset or toggle; compare wins a tie
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wave_state_q <= 1'b0;
    end else if (!wave_enable) begin
      wave_state_q <= 1'b0;
    end else if (match_evt) begin
      wave_state_q <= wave_toggle_select_q ? !wave_state_q : 1'b0;
    end else if (zero_evt && !wave_toggle_select_q) begin
      wave_state_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wave_out_q <= 1'b0;
    end else begin
      wave_out_q <= wave_enable ? (wave_state_q ^ wave_polarity) : wave_polarity;
    end
  end

  assign wave_out = wave_out_q;

  // ****************************************
  // Overflow output
  // ****************************************
  logic wrap_state_q;
  logic wrap_out_q;

  // set until flag clears, or toggle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrap_state_q <= 1'b0;
    end else if (!wrap_out_enable) begin
      wrap_state_q <= 1'b0;
    end else if (core.wrap_event) begin
      wrap_state_q <= core.wrap_toggle_select ? !wrap_state_q : 1'b1;
    end else if (!core.wrap_toggle_select && !core.wrap_flag) begin
      wrap_state_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrap_out_q <= 1'b0;
    end else begin
      wrap_out_q <= wrap_out_enable ? (wrap_state_q ^ wrap_out_polarity) : wrap_out_polarity;
    end
  end

  assign wrap_out_pin = wrap_out_q;

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = arl_timer_pkg::BYTE_RST;
    case (bus_req.addr)
      arl_timer_pkg::MASK_LO_ADDR: rd_mux = mask_q[7:0];
      arl_timer_pkg::FLAGS_ADDR: rd_mux = {edge_b_polarity_q, edge_b_irq_enable_q,
        edge_b_flag_q, match_irq_enable_q, match_flag_q, zero_irq_enable_q, zero_flag_q,
        wave_toggle_select_q};
      arl_timer_pkg::PINCFG_ADDR: rd_mux = {4'h0, pincfg_q} & arl_timer_pkg::PINCFG_MASK;
      arl_timer_pkg::RELOAD_CAPTURE_HIGH_HI_ADDR: rd_mux = reload_capture_q[15:8];
      arl_timer_pkg::RELOAD_CAPTURE_HIGH_LO_ADDR: rd_mux = reload_capture_q[7:0];
      arl_timer_pkg::CAPT_HI_ADDR: rd_mux = capture_q[15:8];
      arl_timer_pkg::CAPT_LO_ADDR: rd_mux = capture_q[7:0];
      arl_timer_pkg::CMP_HI_ADDR: rd_mux = compare_q[15:8];
      arl_timer_pkg::CMP_LO_ADDR: rd_mux = compare_q[7:0];
      arl_timer_pkg::MASK_HI_ADDR: rd_mux = mask_q[15:8];
      default: rd_mux = arl_timer_pkg::BYTE_RST;
    endcase
  end

  // Holds zero outside the answer cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= arl_timer_pkg::BYTE_RST;
    end else begin
      bus_rdata <= bus_req.rd ? rd_mux : arl_timer_pkg::BYTE_RST;
    end
  end

endmodule

// file: test/arl_timer_out_checker.sv
// Port-level assertions for the timer output block
`timescale 1ns/100ps
module arl_timer_out_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire arl_timer_pkg::arl_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // Timer side and pins
  input wire arl_timer_pkg::arl_core_t core,
  input wire logic edge_b_input,
  input wire logic wave_out,
  input wire logic wrap_out_pin,
  input wire logic timer_irq,
  input wire logic edge_b_capture
);
  logic [7:0] cfg_q;
  logic pol_q;
  logic seen_q;
  logic wr_flags;
  assign wr_flags = bus_req.wr && bus_req.addr == arl_timer_pkg::FLAGS_ADDR;
  // Shadow of software settings, pins cannot show them directly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= 8'h00;
      pol_q <= 1'b0;
    end else begin
      if (bus_req.wr && bus_req.addr == arl_timer_pkg::PINCFG_ADDR) begin
        cfg_q <= bus_req.wdata;
      end
      if (wr_flags) begin
        pol_q <= bus_req.wdata[7];
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 1'b0;
    end else if (edge_b_capture) begin
      seen_q <= 1'b1;
    end else if (wr_flags && !bus_req.wdata[5]) begin
      seen_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ****************
  // Assertions
  // ****************
  unmapped_zero_a: assert property (
    bus_req.rd && bus_req.addr inside {8'hE1, [8'hE4:8'hE8]} |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  pin_cfg_read_a: assert property (
    bus_req.rd && bus_req.addr == arl_timer_pkg::PINCFG_ADDR
    |=> bus_rdata == (cfg_q & arl_timer_pkg::PINCFG_MASK))
    else $error("pin config readback wrong");
  wrap_off_a: assert property (
    (!cfg_q[2] && $stable(cfg_q))[*2] |-> wrap_out_pin == cfg_q[3])
    else $error("disabled wrap pin not at polarity");
  wave_off_a: assert property (
    (!cfg_q[0] && $stable(cfg_q))[*2] |-> wave_out == cfg_q[1])
    else $error("disabled wave pin not at polarity");
  irq_pair_a: assert property (
    (core.edge_a_flag && core.edge_a_irq_enable) || (core.wrap_flag && core.wrap_irq_enable)
    |-> timer_irq)
    else $error("interrupt missing for enabled flag");
  hold_clear_a: assert property (!core.run_clear |-> !edge_b_capture)
    else $error("capture while held cleared");
  edge_pol_a: assert property (edge_b_capture |-> $past(edge_b_input) == pol_q)
    else $error("capture on wrong edge");
  one_capture_a: assert property (edge_b_capture |-> !seen_q)
    else $error("second capture before flag clear");
  wrap_toggle_a: assert property (
    core.wrap_event && core.wrap_toggle_select && cfg_q[2]
    |=> ##1 wrap_out_pin != $past(wrap_out_pin))
    else $error("wrap pin did not toggle");
  wrap_set_a: assert property (
    core.wrap_event && core.wrap_flag && !core.wrap_toggle_select && cfg_q[2]
    ##1 core.wrap_flag[*2] |-> wrap_out_pin == !cfg_q[3])
    else $error("wrap pin not at active level");
endmodule

bind arl_timer_out arl_timer_out_checker chk (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .core(core), .edge_b_input(edge_b_input), .wave_out(wave_out),
  .wrap_out_pin(wrap_out_pin), .timer_irq(timer_irq), .edge_b_capture(edge_b_capture));

// file: test/arl_core_model.sv
// Behavioural model of the down counter and overflow logic
`timescale 1ns/100ps
module arl_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Controls from the bench
  input wire logic run,
  input wire logic reload_en,
  input wire logic wrap_tgl,
  input wire logic ea_flag,
  input wire logic ea_ien,
  input wire logic wrap_ien,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic wrap_clr,
  // Timer view
  output arl_timer_pkg::arl_core_t core
);
  logic [15:0] count_q;
  logic wflag_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 16'h0000;
    end else if (!run) begin
      count_q <= 16'h0000;
    end else if (load) begin
      count_q <= load_val;
    end else begin
      count_q <= count_q - 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wflag_q <= 1'b0;
    end else if (core.wrap_event) begin
      wflag_q <= 1'b1;
    end else if (wrap_clr) begin
      wflag_q <= 1'b0;
    end
  end
  always_comb begin
    core = '0;
    core.count = count_q;
    core.run_clear = run;
    core.reload_enable = reload_en;
    core.wrap_event = run && !load && count_q == 16'h0000;
    core.wrap_flag = wflag_q;
    core.wrap_irq_enable = wrap_ien;
    core.wrap_toggle_select = wrap_tgl;
    core.edge_a_flag = ea_flag;
    core.edge_a_irq_enable = ea_ien;
  end
endmodule

// file: test/tb_arl_timer_out.sv
// Self-checking bench of the timer output block
`timescale 1ns/100ps
module tb_arl_timer_out;
  logic clk, arst_n, eb_in, run, rl_en, tgl, ea_f, ea_ie, wr_ie, ld, wclr;
  logic [15:0] ld_val;
  logic [7:0] rdata;
  logic wave, wrap_pin, irq, cap;
  arl_timer_pkg::arl_bus_req_t req;
  arl_timer_pkg::arl_core_t core;
  int failures, cmp_count;
  arl_core_model pm (.clk(clk), .arst_n(arst_n), .run(run), .reload_en(rl_en), .wrap_tgl(tgl),
    .ea_flag(ea_f), .ea_ien(ea_ie), .wrap_ien(wr_ie), .load(ld), .load_val(ld_val),
    .wrap_clr(wclr), .core(core));
  arl_timer_out uut (.clk(clk), .arst_n(arst_n), .bus_req(req), .bus_rdata(rdata), .core(core),
    .edge_b_input(eb_in), .wave_out(wave), .wrap_out_pin(wrap_pin), .timer_irq(irq),
    .edge_b_capture(cap));
  // ****************
  // Helpers
  // ****************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic wr16(input logic [7:0] h, input logic [7:0] l, input logic [15:0] v);
    wr(h, v[15:8]);
    wr(l, v[7:0]);
  endtask
  task automatic load(input logic [15:0] n);
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= n;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    logic [15:0] v;
    logic [15:0] w;
    logic [7:0] hi[2];
    logic [7:0] lo[2];
    hi = '{8'hED, 8'hEF};
    lo = '{8'hEE, 8'hE0};
    {arst_n, eb_in, run, rl_en, tgl, ea_f, ea_ie, wr_ie, ld, wclr} = '0;
    ld_val = 16'h0000;
    req = '0;
    void'($urandom(50080));
    step(8);
    arst_n <= 1'b1;
    rchk(8'hED, 8'h00, "cmp_reset");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        v = 16'($urandom);
        w = 16'($urandom);
        wr16(hi[p], lo[p], v);
        wr(hi[p], w[15:8]);
        rchk(hi[p], v[15:8], "hi_before_low");
        wr(lo[p], w[7:0]);
        rchk(hi[p], w[15:8], "hi_after_low");
        rchk(lo[p], w[7:0], "lo_byte");
      end
    end
    $display("pairing test done");
    wr16(8'hE9, 8'hEA, 16'h1234);
    rchk(8'hE9, 8'h00, "reload_locked");
    step(1);
    rl_en <= 1'b1;
    wr16(8'hE9, 8'hEA, 16'h1234);
    rchk(8'hEA, 8'h34, "reload_open");
    wr16(8'hEB, 8'hEC, 16'hFFFF);
    rchk(8'hEB, 8'h00, "capture_ro");
    wr(8'hE3, 8'hFF);
    rchk(8'hE3, 8'h0F, "reserved_bits");
    rchk(8'hE5, 8'h00, "unmapped");
    $display("access test done");
    wr(8'hE3, 8'h00);
    wr16(8'hEF, 8'hE0, 16'hFFFF);
    wr16(8'hED, 8'hEE, 16'h0006);
    step(5);
    rchk(8'hE2, 8'h00, "held_flags");
    step(1);
    run <= 1'b1;
    load(16'd20);
    step(25);
    rchk(8'hE2, 8'h0A, "flags_set");
    chk("irq_masked", 1'b0, irq);
    wr(8'hE2, 8'h1A);
    #1 chk("match_irq", 1'b1, irq);
    wr(8'hE2, 8'h0E);
    #1 chk("zero_irq", 1'b1, irq);
    step(1);
    {ea_f, ea_ie} <= 2'b11;
    wr(8'hE2, 8'h0A);
    #1 chk("edge_a_irq", 1'b1, irq);
    step(1);
    {ea_f, ea_ie} <= 2'b00;
    wr(8'hE2, 8'h00);
    wr(8'hE2, 8'h2A);
    rchk(8'hE2, 8'h00, "no_sw_set");
    $display("flag test done");
    for (int pl = 0; pl < 2; pl++) begin
      wr(8'hE3, {6'h00, pl[0], 1'b0});
      step(3);
      #1 chk("wave_off", pl[0], wave);
      wr(8'hE3, {6'h00, pl[0], 1'b1});
      load(16'd12);
      step(9);
      #1 chk("wave_compare", pl[0], wave);
      step(8);
      #1 chk("wave_zero", !pl[0], wave);
      load(16'd12);
      step(9);
      #1 chk("wave_reset", pl[0], wave);
    end
    wr(8'hE2, 8'h01);
    wr(8'hE3, 8'h01);
    load(16'd12);
    step(9);
    #1 chk("wave_toggle", 1'b1, wave);
    step(8);
    #1 chk("wave_no_zero", 1'b1, wave);
    $display("wave test done");
    for (int pl = 0; pl < 2; pl++) begin
      wr(8'hE2, {pl[0], 7'h00});
      step(1);
      eb_in <= !pl[0];
      step(6);
      rchk(8'hE2, {pl[0], 7'h00}, "idle_edge");
      step(1);
      eb_in <= pl[0];
      step(6);
      rchk(8'hE2, {pl[0], 7'h20}, "active_edge");
      chk("edge_masked", 1'b0, irq);
      step(1);
      eb_in <= !pl[0];
      step(6);
      eb_in <= pl[0];
      step(6);
      wr(8'hE2, {pl[0], 7'h60});
      #1 chk("edge_irq", 1'b1, irq);
      wr(8'hE2, {pl[0], 7'h00});
    end
    $display("edge test done");
    step(1);
    wr_ie <= 1'b1;
    for (int pl = 0; pl < 2; pl++) begin
      wr(8'hE3, {4'h0, pl[0], 3'b100});
      load(16'd3);
      step(5);
      load(16'd3);
      step(6);
      #1 chk("wrap_set", !pl[0], wrap_pin);
      step(1);
      wclr <= 1'b1;
      step(1);
      wclr <= 1'b0;
      step(3);
      #1 chk("wrap_restore", pl[0], wrap_pin);
      step(1);
      tgl <= 1'b1;
      load(16'd3);
      step(6);
      #1 chk("wrap_toggle", !pl[0], wrap_pin);
      step(1);
      tgl <= 1'b0;
      wclr <= 1'b1;
      step(1);
      wclr <= 1'b0;
    end
    $display("wrap pin test done");
    conclude();
  end
endmodule
